//--- rtl/ppf_top.sv
// Purpose: Port pin function control with AXI4-Lite registers and debug-reset pin handling.
// Assumes: MCLK_IN at 40 MHz; internal reset requests are one-clock-domain levels or pulses.
// Notes: Pin levels pass two flip-flops; all top outputs except S_AXI_ARREADY come from flip-flops.
`timescale 1ns/10ps
`include "ppf_params.svh"

// Contract
// - Select bit 0 port, 1 alternate.
// - Alternate input is select AND pin.
// - Select change seen as edge; configure after.
// - Open-drain only acts with direction output; the code also applies it in alternate mode whatever the direction.
// - Write hits latch; read pins or latch.
// - Bit operation: 8-bit read, modify, write.
// - External reset gives shared pin debug function.
// - High debug pin enters debug, releases pins.
// - Internal resets keep debug function and control.
// - Pull-down on after reset, off when cleared.
module ppf_top
  import ppf_pkg::*;
#(
  parameter int PORT_WIDTH = 8
)
(
  // Clock and resets.
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic WDT_RESET_IN,
  input wire logic CLM_RESET_IN,
  input wire logic LVI_RESET_IN,
  // AXI4-Lite write address and data.
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [`PPF_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response.
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read.
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [`PPF_ADDR_W-1:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Pins.
  input wire logic [PORT_WIDTH-1:0] PIN_IN,
  output logic [PORT_WIDTH-1:0] PIN_OUT,
  output logic [PORT_WIDTH-1:0] PIN_OE_N_OUT,
  output logic PULLDOWN_EN_OUT,
  // Peripheral function blocks.
  input wire logic [PORT_WIDTH-1:0] ALT_OUT_IN,
  input wire logic [PORT_WIDTH-1:0] ALT_OE_IN,
  output logic [PORT_WIDTH-1:0] ALT_IN_OUT,
  output logic [PORT_WIDTH-1:0] FUNC_SELECT_OUT,
  output logic [PORT_WIDTH-1:0] FUNC_CHOICE_OUT,
  output logic [PORT_WIDTH-1:0] FUNC_CHOICE_EXT_OUT,
  // Debug and interrupt.
  output logic DEBUG_PINS_RELEASE_OUT,
  output logic IRQ_OUT
);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  // Bit operations and the byte-wide register file are defined for eight pins only.
  if (PORT_WIDTH != 8)
  begin : g_width_check
    $error("ppf_top supports PORT_WIDTH of 8 only");
  end

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic rst_meta_q, rst_n_q;
  logic [7:0] pin_meta_q, pin_sync_q;
  ppf_byte_t port_latch_q, direction_q, func_select_q, open_drain_q;
  ppf_byte_t func_choice_q, func_choice_ext_q;
  logic debug_en_q, debug_mode_q;
  logic [`PPF_NUM_EVENTS-1:0] irq_status_q, irq_enable_q, irq_event;
  logic shared_alt_prev_q, internal_rst;
  logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q;
  logic [`PPF_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q, wr_do, wr_hit;
  ppf_resp_t bresp_q, rresp_q;
  ppf_rd_state_t rd_state_q;
  logic [31:0] rdata_q;
  logic [7:0] drv_val, drv_oe_n, alt_in;
  logic [7:0] pin_out_q, pin_oe_n_q, alt_in_q;
  logic irq_q;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Port data read view: input bits show the pin, output bits show the latch.
  function automatic ppf_byte_t port_read(input ppf_byte_t dir, input ppf_byte_t latch,
                                          input ppf_byte_t pins);
    port_read = (dir & pins) | (~dir & latch);
  endfunction

  // Address decode shared by the write and read paths.
  function automatic logic is_mapped(input logic [`PPF_ADDR_W-1:0] addr, input logic for_write);
    unique case (addr)
      `PPF_OFF_PORT_DATA, `PPF_OFF_DIRECTION, `PPF_OFF_FUNC_SELECT, `PPF_OFF_OPEN_DRAIN,
      `PPF_OFF_FUNC_CHOICE, `PPF_OFF_FUNC_CHOICE_EXT, `PPF_OFF_DEBUG_CTRL,
      `PPF_OFF_IRQ_ENABLE: is_mapped = 1'b1;
      `PPF_OFF_BIT_OP, `PPF_OFF_IRQ_CLEAR: is_mapped = for_write;
      `PPF_OFF_IRQ_STATUS: is_mapped = ~for_write;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Reset and pin synchronisers
  // --------------------------------------------------------------------------
  // External reset is released through two flip-flops.
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Pin levels come from outside the clock domain; only the second stage is read.
  always_ff @(posedge MCLK_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pin_meta_q <= `PPF_RST_BYTE;
      pin_sync_q <= `PPF_RST_BYTE;
    end
    else
    begin
      pin_meta_q <= PIN_IN;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Watchdog, clock monitor and low-voltage resets clear the port but not debug state.
  assign internal_rst = WDT_RESET_IN | CLM_RESET_IN | LVI_RESET_IN;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  // Address and data are held separately, in either order; the write fires once both are in.
  assign wr_do = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_hit = wr_do & is_mapped(awaddr_q, 1'b1) & wstrb0_q;

  // Channel holding flags and handshakes; one write at a time.
  always_ff @(posedge MCLK_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `PPF_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      if (S_AXI_AWVALID && awready_q)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      else if (wr_do)
      begin
        aw_held_q <= 1'b0;
      end
      if (S_AXI_WVALID && wready_q)
      begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb0_q <= S_AXI_WSTRB[0];
      end
      else if (wr_do)
      begin
        w_held_q <= 1'b0;
      end
      // Ready drops as soon as the item is taken and rises again after the response.
      awready_q <= ~(aw_held_q | (S_AXI_AWVALID & awready_q)) & ~bvalid_q & ~wr_do;
      wready_q <= ~(w_held_q | (S_AXI_WVALID & wready_q)) & ~bvalid_q & ~wr_do;
      if (wr_do)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q, 1'b1) ? `PPF_RESP_OKAY : `PPF_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Port configuration registers
  // --------------------------------------------------------------------------
  // Port registers change on a clock edge after a bus write or an internal reset; byte lane 0 is stored, and the bit operation also takes bit 8.
  always_ff @(posedge MCLK_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      port_latch_q <= `PPF_RST_BYTE;
      direction_q <= `PPF_RST_DIRECTION;
      func_select_q <= `PPF_RST_BYTE;
      open_drain_q <= `PPF_RST_BYTE;
      func_choice_q <= `PPF_RST_BYTE;
      func_choice_ext_q <= `PPF_RST_BYTE;
    end
    else if (internal_rst)
    begin
      port_latch_q <= `PPF_RST_BYTE;
      direction_q <= `PPF_RST_DIRECTION;
      func_select_q <= `PPF_RST_BYTE;
      open_drain_q <= `PPF_RST_BYTE;
      func_choice_q <= `PPF_RST_BYTE;
      func_choice_ext_q <= `PPF_RST_BYTE;
    end
    else if (wr_hit)
    begin
      unique case (awaddr_q)
        `PPF_OFF_PORT_DATA: port_latch_q <= wdata_q[7:0];
        // The bit operation copies pin levels of input bits into their latches by design.
        `PPF_OFF_BIT_OP:
        begin
          port_latch_q <= port_read(direction_q, port_latch_q, pin_sync_q);
          port_latch_q[wdata_q[`PPF_BITOP_IDX_MSB:0]] <= wdata_q[`PPF_BITOP_SET_POS];
        end
        `PPF_OFF_DIRECTION: direction_q <= wdata_q[7:0];
        `PPF_OFF_FUNC_SELECT: func_select_q <= wdata_q[7:0];
        `PPF_OFF_OPEN_DRAIN: open_drain_q <= wdata_q[7:0];
        `PPF_OFF_FUNC_CHOICE: func_choice_q <= wdata_q[7:0];
        `PPF_OFF_FUNC_CHOICE_EXT: func_choice_ext_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Debug-reset pin control
  // --------------------------------------------------------------------------
  // Only the external reset restores the debug function; internal resets leave it alone.
  always_ff @(posedge MCLK_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      debug_en_q <= `PPF_RST_DEBUG_EN;
      debug_mode_q <= 1'b0;
    end
    else
    begin
      if (wr_hit && awaddr_q == `PPF_OFF_DEBUG_CTRL)
      begin
        debug_en_q <= wdata_q[`PPF_DEBUG_EN_POS];
      end
      // A high level on the debug-reset input while it holds that function enters debug mode.
      if (!debug_en_q)
      begin
        debug_mode_q <= 1'b0;
      end
      else if (pin_sync_q[`PPF_SHARED_PIN])
      begin
        debug_mode_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin slices
  // --------------------------------------------------------------------------
  // One slice per pin; the shared pin is held off while it carries the debug-reset input.
  for (genvar i = 0; i < PORT_WIDTH; i++)
  begin : g_pin
    ppf_pin_slice u_slice
    (
      .sel_in(func_select_q[i]),
      .dir_in(direction_q[i]),
      .od_in(open_drain_q[i]),
      .latch_in(port_latch_q[i]),
      .debug_hold_in(debug_en_q && (i == `PPF_SHARED_PIN)),
      .alt_out_in(ALT_OUT_IN[i]),
      .alt_oe_in(ALT_OE_IN[i]),
      .pin_in(pin_sync_q[i]),
      .drv_val_out(drv_val[i]),
      .drv_oe_n_out(drv_oe_n[i]),
      .alt_in_out(alt_in[i])
    );
  end

  // Registered pin outputs; drivers stay off through reset.
  always_ff @(posedge MCLK_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pin_out_q <= `PPF_RST_BYTE;
      pin_oe_n_q <= `PPF_RST_OE_N;
      alt_in_q <= `PPF_RST_BYTE;
    end
    else
    begin
      pin_out_q <= drv_val;
      pin_oe_n_q <= drv_oe_n;
      alt_in_q <= alt_in;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  // The shared edge follows the gated input, so a select change on a high pin is an edge too.
  assign irq_event[`PPF_EV_DEBUG_ENTRY] = debug_en_q & pin_sync_q[`PPF_SHARED_PIN] & ~debug_mode_q;
  assign irq_event[`PPF_EV_SHARED_EDGE] = alt_in_q[`PPF_SHARED_PIN] & ~shared_alt_prev_q;

  // Sticky status: a new event in the same cycle as its clear keeps the bit set.
  always_ff @(posedge MCLK_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      irq_status_q <= `PPF_RST_IRQ;
      irq_enable_q <= `PPF_RST_IRQ;
      shared_alt_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      shared_alt_prev_q <= alt_in_q[`PPF_SHARED_PIN];
      if (wr_hit && awaddr_q == `PPF_OFF_IRQ_CLEAR)
      begin
        irq_status_q <= (irq_status_q & ~wdata_q[`PPF_NUM_EVENTS-1:0]) | irq_event;
      end
      else
      begin
        irq_status_q <= irq_status_q | irq_event;
      end
      if (wr_hit && awaddr_q == `PPF_OFF_IRQ_ENABLE)
      begin
        irq_enable_q <= wdata_q[`PPF_NUM_EVENTS-1:0];
      end
      irq_q <= |(irq_status_q & irq_enable_q);
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  // Data is captured at the address handshake; the next request waits for rready.
  always_ff @(posedge MCLK_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rd_state_q <= PPF_RD_IDLE;
      rdata_q <= '0;
      rresp_q <= `PPF_RESP_OKAY;
    end
    else
    begin
      unique case (rd_state_q)
        PPF_RD_IDLE:
        begin
          if (S_AXI_ARVALID)
          begin
            rd_state_q <= PPF_RD_RESP;
            rresp_q <= is_mapped(S_AXI_ARADDR, 1'b0) ? `PPF_RESP_OKAY : `PPF_RESP_SLVERR;
            rdata_q <= '0;
            unique case (S_AXI_ARADDR)
              `PPF_OFF_PORT_DATA: rdata_q[7:0] <= port_read(direction_q, port_latch_q, pin_sync_q);
              `PPF_OFF_DIRECTION: rdata_q[7:0] <= direction_q;
              `PPF_OFF_FUNC_SELECT: rdata_q[7:0] <= func_select_q;
              `PPF_OFF_OPEN_DRAIN: rdata_q[7:0] <= open_drain_q;
              `PPF_OFF_FUNC_CHOICE: rdata_q[7:0] <= func_choice_q;
              `PPF_OFF_FUNC_CHOICE_EXT: rdata_q[7:0] <= func_choice_ext_q;
              `PPF_OFF_DEBUG_CTRL:
              begin
                rdata_q[`PPF_DEBUG_EN_POS] <= debug_en_q;
                rdata_q[`PPF_DEBUG_MODE_POS] <= debug_mode_q;
              end
              `PPF_OFF_IRQ_STATUS: rdata_q[`PPF_NUM_EVENTS-1:0] <= irq_status_q;
              `PPF_OFF_IRQ_ENABLE: rdata_q[`PPF_NUM_EVENTS-1:0] <= irq_enable_q;
              default: ;
            endcase
          end
        end
        PPF_RD_RESP:
        begin
          if (S_AXI_RREADY)
          begin
            rd_state_q <= PPF_RD_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Output assignments
  // --------------------------------------------------------------------------
  // Each output is a flip-flop except S_AXI_ARREADY, which gates the read state with the reset; the pull-down follows the debug enable bit.
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = (rd_state_q == PPF_RD_IDLE) & rst_n_q;
  assign S_AXI_RVALID = (rd_state_q == PPF_RD_RESP);
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign PIN_OUT = pin_out_q;
  assign PIN_OE_N_OUT = pin_oe_n_q;
  assign PULLDOWN_EN_OUT = debug_en_q;
  assign ALT_IN_OUT = alt_in_q;
  assign FUNC_SELECT_OUT = func_select_q;
  assign FUNC_CHOICE_OUT = func_choice_q;
  assign FUNC_CHOICE_EXT_OUT = func_choice_ext_q;
  assign DEBUG_PINS_RELEASE_OUT = debug_mode_q;
  assign IRQ_OUT = irq_q;

endmodule

//--- pkg/ppf_params.svh
// Purpose: Named constants for the port pin function control block.
// Assumes: Included by its bare name; definitions only.
// Notes: Offsets are byte addresses of aligned 32-bit words on the AXI4-Lite slave.
`ifndef PPF_PARAMS_SVH
`define PPF_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PPF_ADDR_W 6
`define PPF_OFF_PORT_DATA 6'h00
`define PPF_OFF_DIRECTION 6'h04
`define PPF_OFF_FUNC_SELECT 6'h08
`define PPF_OFF_OPEN_DRAIN 6'h0C
`define PPF_OFF_FUNC_CHOICE 6'h10
`define PPF_OFF_FUNC_CHOICE_EXT 6'h14
`define PPF_OFF_BIT_OP 6'h18
`define PPF_OFF_DEBUG_CTRL 6'h1C
`define PPF_OFF_IRQ_STATUS 6'h20
`define PPF_OFF_IRQ_CLEAR 6'h24
`define PPF_OFF_IRQ_ENABLE 6'h28

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PPF_RST_DIRECTION 8'hFF
`define PPF_RST_OE_N 8'hFF
`define PPF_RST_BYTE 8'h00
`define PPF_RST_DEBUG_EN 1'b1
`define PPF_RST_IRQ 2'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PPF_BITOP_IDX_MSB 2
`define PPF_BITOP_SET_POS 8
`define PPF_DEBUG_EN_POS 0
`define PPF_DEBUG_MODE_POS 1
`define PPF_EV_DEBUG_ENTRY 0
`define PPF_EV_SHARED_EDGE 1
`define PPF_SHARED_PIN 5
`define PPF_NUM_EVENTS 2

// ----------------------------------------------------------------------------
// AXI4-Lite response codes
// ----------------------------------------------------------------------------
`define PPF_RESP_OKAY 2'h0
`define PPF_RESP_SLVERR 2'h2

`endif

//--- pkg/ppf_pkg.sv
// Purpose: Types shared by the port pin function control block.
// Assumes: Constants come from ppf_params.svh.
// Notes: Types only; numbers live in the header.
package ppf_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef logic [7:0] ppf_byte_t;
  typedef logic [1:0] ppf_resp_t;
  typedef enum logic [0:0] {PPF_RD_IDLE, PPF_RD_RESP} ppf_rd_state_t;

endpackage

//--- rtl/ppf_pin_slice.sv
// Purpose: Pin driver and alternate-input gating for one port pin.
// Assumes: All inputs are on the system clock; the pin level is already synchronised.
// Notes: Purely combinational; the top registers the results.
`timescale 1ns/10ps
module ppf_pin_slice
(
  // Configuration bits of this pin.
  input wire logic sel_in,
  input wire logic dir_in,
  input wire logic od_in,
  input wire logic latch_in,
  input wire logic debug_hold_in,
  // Peripheral side.
  input wire logic alt_out_in,
  input wire logic alt_oe_in,
  // Synchronised pin level.
  input wire logic pin_in,
  // Results.
  output logic drv_val_out,
  output logic drv_oe_n_out,
  output logic alt_in_out
);

  // Driver selection: debug hold wins, then the function select picks the owner.
  always_comb
  begin
    drv_val_out = 1'b0;
    drv_oe_n_out = 1'b1;
    if (debug_hold_in)
    begin
      drv_oe_n_out = 1'b1; // Debug-reset input function keeps the driver off.
    end
    else if (sel_in)
    begin
      // The peripheral governs the driver; open drain only ever pulls low.
      drv_val_out = od_in ? 1'b0 : alt_out_in;
      drv_oe_n_out = ~alt_oe_in | (od_in & alt_out_in);
    end
    else if (!dir_in)
    begin
      // Output mode: the only port-mode use of the open-drain bit; the alternate branch above also uses it with dir=1.
      drv_val_out = od_in ? 1'b0 : latch_in;
      drv_oe_n_out = od_in & latch_in;
    end
  end

  // The peripheral sees the pin ANDed with the select bit, so it reads low in port mode.
  assign alt_in_out = sel_in & pin_in & ~debug_hold_in;

endmodule

//--- sim/ppf_top_assertions.sv
// Purpose: Port-level timing relations of the port pin block.
// Assumes: One clock; the external pin reset disables every check.
// Notes: Bound from the testbench top file.
`timescale 1ns/10ps
module ppf_top_assertions
(
  // Clock and reset.
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  // Bus handshakes.
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  // Pins and peripherals.
  input wire logic [7:0] PIN_IN,
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PIN_OE_N_OUT,
  input wire logic PULLDOWN_EN_OUT,
  input wire logic [7:0] ALT_OUT_IN,
  input wire logic [7:0] ALT_OE_IN,
  input wire logic [7:0] ALT_IN_OUT,
  input wire logic [7:0] FUNC_SELECT_OUT,
  input wire logic DEBUG_PINS_RELEASE_OUT
);
  // All checks share the system clock and the pin reset.
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_alt_gate; (ALT_IN_OUT & ~$past(FUNC_SELECT_OUT)) == 8'h00; endproperty
  a_alt_gate: assert property (p_alt_gate) else $error("alt input high with select low");
  property p_alt_off; FUNC_SELECT_OUT[0] && !ALT_OE_IN[0] |=> PIN_OE_N_OUT[0]; endproperty
  a_alt_off: assert property (p_alt_off) else $error("pin driven without peripheral enable");
  property p_alt_drv; FUNC_SELECT_OUT[0] && ALT_OE_IN[0] && !ALT_OUT_IN[0] |=> !PIN_OE_N_OUT[0] && !PIN_OUT[0]; endproperty
  a_alt_drv: assert property (p_alt_drv) else $error("peripheral drive not on pin");
  property p_pd_rst; $rose(RESET_N_IN) |-> PULLDOWN_EN_OUT; endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("pull-down off after pin reset");
  property p_pd_hold; PULLDOWN_EN_OUT |=> PIN_OE_N_OUT[5]; endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("debug pin driven in debug function");
  property p_dbg_in; $rose(DEBUG_PINS_RELEASE_OUT) |-> $past(PULLDOWN_EN_OUT) && $past(PIN_IN[5], 3); endproperty
  a_dbg_in: assert property (p_dbg_in) else $error("debug mode without high debug pin");
  property p_dbg_out; !PULLDOWN_EN_OUT |=> !DEBUG_PINS_RELEASE_OUT; endproperty
  a_dbg_out: assert property (p_dbg_out) else $error("debug mode kept after enable cleared");
  property p_r_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_b_ans; S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:3] S_AXI_BVALID; endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
endmodule

//--- sim/ppf_pin_env.sv
// Purpose: Board wiring of the eight pins.
// Assumes: Board drivers are set by the testbench.
// Notes: The device driver wins over the board.
`timescale 1ns/10ps
module ppf_pin_env
(
  // Clock.
  input wire logic clk_in,
  // Device side of the pins.
  input wire logic [7:0] drv_in,
  input wire logic [7:0] oe_n_in,
  input wire logic pd_in,
  // Board drivers.
  input wire logic [7:0] ext_val_in,
  input wire logic [7:0] ext_en_in,
  // Resolved levels.
  output logic [7:0] lvl_out
);
  logic flt_q = 1'b0;
  // A released, unpulled line wanders, so a stale level is never mistaken for a driven one.
  always_ff @(posedge clk_in) flt_q <= ~flt_q;
  // Pin 5 falls to the pull-down when nothing drives it.
  always_comb
    for (int i = 0; i < 8; i++)
      lvl_out[i] = !oe_n_in[i] ? drv_in[i] : ext_en_in[i] ? ext_val_in[i] : (i == 5 && pd_in) ? 1'b0 : flt_q;
endmodule

//--- sim/ppf_top_tb.sv
// Purpose: Register and pin scenarios for the port pin block.
// Assumes: Bus tasks keep one transfer at a time.
// Notes: Expected values are worked out by hand from the register map.
`timescale 1ns/10ps
`include "ppf_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module ppf_top_tb;
  import ppf_pkg::*;
  logic clk = 0, rst_n = 0, wdt = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [5:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, rdat;
  ppf_byte_t ext_val = 8'hA5, ext_en = 8'hDF, alt_out = 0, alt_oe = 0, lvl, pout, poe, alt_in, fsel, fch, fche;
  logic awr, wrdy, bv, arr, rv, pd, dbg, irq;
  ppf_resp_t br, rr;
  int errors = 0, compares = 0, cyc = 0;
  // Free-running 40 MHz clock.
  initial forever #12.5 clk = ~clk;
  ppf_top u_dut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .WDT_RESET_IN(wdt), .CLM_RESET_IN(wdt), .LVI_RESET_IN(wdt),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(aw), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_BRESP(br),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ar), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .PIN_IN(lvl), .PIN_OUT(pout), .PIN_OE_N_OUT(poe), .PULLDOWN_EN_OUT(pd),
    .ALT_OUT_IN(alt_out), .ALT_OE_IN(alt_oe), .ALT_IN_OUT(alt_in), .FUNC_SELECT_OUT(fsel),
    .FUNC_CHOICE_OUT(fch), .FUNC_CHOICE_EXT_OUT(fche), .DEBUG_PINS_RELEASE_OUT(dbg), .IRQ_OUT(irq));
  ppf_pin_env u_env (.clk_in(clk), .drv_in(pout), .oe_n_in(poe), .pd_in(pd), .ext_val_in(ext_val),
    .ext_en_in(ext_en), .lvl_out(lvl));
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input ppf_resp_t r);
    @(posedge clk);
    awv <= 1'b1; wv <= 1'b1; aw <= a; wd <= d; bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (!bv);
    bready <= 1'b0;
    `CHK(br, r)
  endtask
  // Read: one word, checked against data and response.
  task automatic rd(input logic [5:0] a, input logic [31:0] d, input ppf_resp_t r);
    @(posedge clk);
    arv <= 1'b1; ar <= a; rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
    rready <= 1'b0;
    `CHK(rdat, d)
    `CHK(rr, r)
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({pd, dbg, alt_in}, 10'h200)
    rd(`PPF_OFF_DIRECTION, 32'h0000_00FF, `PPF_RESP_OKAY);
    rd(`PPF_OFF_DEBUG_CTRL, 32'h0000_0001, `PPF_RESP_OKAY);
    ext_en <= 8'hFF;
    repeat (5) @(posedge clk);
    `CHK(dbg, 1'b1)
    rd(`PPF_OFF_DEBUG_CTRL, 32'h0000_0003, `PPF_RESP_OKAY);
    wr(`PPF_OFF_IRQ_ENABLE, 32'h0000_0001, `PPF_RESP_OKAY);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(`PPF_OFF_IRQ_ENABLE, 32'h0000_0000, `PPF_RESP_OKAY);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(`PPF_OFF_IRQ_CLEAR, 32'h0000_0001, `PPF_RESP_OKAY);
    rd(`PPF_OFF_IRQ_STATUS, 32'h0000_0000, `PPF_RESP_OKAY);
    ext_en <= 8'hDF;
    wr(`PPF_OFF_DEBUG_CTRL, 32'h0000_0000, `PPF_RESP_OKAY);
    ext_en <= 8'hFF;
    repeat (2) @(posedge clk);
    `CHK({pd, dbg}, 2'b00)
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    rd(`PPF_OFF_DEBUG_CTRL, 32'h0000_0000, `PPF_RESP_OKAY);
    wr(`PPF_OFF_DIRECTION, 32'h0000_000F, `PPF_RESP_OKAY);
    wr(`PPF_OFF_PORT_DATA, 32'h0000_003C, `PPF_RESP_OKAY);
    repeat (4) @(posedge clk);
    rd(`PPF_OFF_PORT_DATA, 32'h0000_0035, `PPF_RESP_OKAY);
    `CHK({poe, pout[7:4]}, 12'h0F3)
    wr(`PPF_OFF_BIT_OP, 32'h0000_0107, `PPF_RESP_OKAY);
    wr(`PPF_OFF_DIRECTION, 32'h0000_0000, `PPF_RESP_OKAY);
    rd(`PPF_OFF_PORT_DATA, 32'h0000_00B5, `PPF_RESP_OKAY);
    wr(`PPF_OFF_BIT_OP, 32'h0000_0002, `PPF_RESP_OKAY);
    rd(`PPF_OFF_PORT_DATA, 32'h0000_00B1, `PPF_RESP_OKAY);
    wr(`PPF_OFF_PORT_DATA, 32'h0000_003C, `PPF_RESP_OKAY);
    wr(`PPF_OFF_DIRECTION, 32'h0000_000F, `PPF_RESP_OKAY);
    wr(`PPF_OFF_OPEN_DRAIN, 32'h0000_00F0, `PPF_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK({poe, pout[7:4]}, 12'h3F0)
    wr(`PPF_OFF_FUNC_CHOICE, 32'h0000_005A, `PPF_RESP_OKAY);
    wr(`PPF_OFF_FUNC_CHOICE_EXT, 32'h0000_00A5, `PPF_RESP_OKAY);
    `CHK({fch, fche}, 16'h5AA5)
    wr(`PPF_OFF_FUNC_SELECT, 32'h0000_0005, `PPF_RESP_OKAY);
    alt_oe <= 8'h01;
    repeat (5) @(posedge clk);
    `CHK({fsel, poe[2:0], alt_in[2:0]}, 14'h174)
    alt_out <= 8'h01;
    repeat (5) @(posedge clk);
    `CHK({pout[0], alt_in[0]}, 2'b11)
    wr(`PPF_OFF_IRQ_ENABLE, 32'h0000_0002, `PPF_RESP_OKAY);
    wr(`PPF_OFF_FUNC_SELECT, 32'h0000_0025, `PPF_RESP_OKAY);
    repeat (4) @(posedge clk);
    `CHK(irq, 1'b1)
    rd(`PPF_OFF_IRQ_STATUS, 32'h0000_0002, `PPF_RESP_OKAY);
    wr(`PPF_OFF_IRQ_ENABLE, 32'h0000_0000, `PPF_RESP_OKAY);
    alt_oe <= 8'h00;
    wr(`PPF_OFF_FUNC_SELECT, 32'h0000_0000, `PPF_RESP_OKAY);
    repeat (4) @(posedge clk);
    `CHK({alt_in, irq}, 9'h000)
    rd(6'h30, 32'h0000_0000, `PPF_RESP_SLVERR);
    rd(`PPF_OFF_BIT_OP, 32'h0000_0000, `PPF_RESP_SLVERR);
    wr(`PPF_OFF_IRQ_STATUS, 32'h0000_0003, `PPF_RESP_SLVERR);
    wrap_up();
  end
endmodule
bind ppf_top ppf_top_assertions u_chk (.*);
